// ### logic/spms_regs.vh
// constants for the master/slave serial peripheral port
// What this block does
// - master: data-in line is input; slave: block drives it toward master
// - master: data-out line driven with transmit data; slave: it is an input
// - serial clock driven only in master mode; slave mode only receives it
// - serial clock never faster than one sixteenth of the core clock
// - master mode drives select0/slave-enable pin as a slave select output
// - slave mode: select0/slave-enable is active-low enable; high ignores transfers
// - slave select 1 driven only in master mode, unused in slave mode
// - slave select 1 is active low and can be released to high impedance
// - after reset every shared pin acts as its port C general-purpose I/O
// - I/O configuration settings choose serial or general-purpose function per pin
// - slave select 3 behaves like slave select 1
`ifndef SPMS_REGS_VH
`define SPMS_REGS_VH
`define SPMS_MIN_DIV       8'h08
`define SPMS_LEN_W        5
`define SPMS_DATA_W       32
`define SPMS_PIN_MISO     3'h0
`define SPMS_PIN_MOSI     3'h1
`define SPMS_PIN_SCK      3'h2
`define SPMS_PIN_SEL0     3'h3
`define SPMS_PIN_SEL1     3'h4
`define SPMS_PIN_SEL3     3'h5
`define SPMS_NPINS        6
`endif

// ### logic/spms_sync.v
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module spms_sync #(
    parameter W = 1
) (
    input  wire         clock,
    input  wire         reset,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta;
    // first stage read only by second stage
    always @(posedge clock) begin
        if (reset) begin
            meta <= {W{1'b1}};
            dout <= {W{1'b1}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // spms_sync

// ### logic/spms_clkdiv.v
// half-period enable divider for the master serial clock
`timescale 1ns/1ps
`include "spms_regs.vh"
module spms_clkdiv (
    input  wire       clock,
    input  wire       reset,
    input  wire       run,
    input  wire [7:0] half_div,
    output reg        tick
);
    reg  [7:0] cnt;
    wire [7:0] lim;
    // clamp keeps sck at or below clock/16
    assign lim = (half_div < `SPMS_MIN_DIV) ? `SPMS_MIN_DIV : half_div;
    always @(posedge clock) begin
        if (reset || !run) begin
            cnt  <= 8'h00;
            tick <= 1'b0;
        end else if (cnt >= lim - 8'h01) begin
            cnt  <= 8'h00;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule // spms_clkdiv

// ### logic/spms_port.v
// master/slave serial peripheral port with port C pin sharing
`timescale 1ns/1ps
`include "spms_regs.vh"
module spms_port #(
    parameter DW = `SPMS_DATA_W
) (
    input  wire                  clock,
    input  wire                  reset,
    // pin function choice and the general-purpose side
    input  wire [`SPMS_NPINS-1:0] pin_serial_sel,
    input  wire [`SPMS_NPINS-1:0] gpio_out,
    input  wire [`SPMS_NPINS-1:0] gpio_oe_n,
    output reg  [`SPMS_NPINS-1:0] gpio_in,
    // transfer control
    input  wire                  master_mode,
    input  wire [7:0]            half_div,
    input  wire [`SPMS_LEN_W-1:0] xfer_len,
    input  wire                  cpol,
    input  wire [1:0]            sel_choice,
    input  wire                  start,
    input  wire [DW-1:0]         tx_data,
    output reg  [DW-1:0]         rx_data,
    output reg                   done,
    output reg                   busy,
    // shared pins: input, output and active-low output enable
    input  wire                  port_c_bit5_in,
    output reg                   port_c_bit5_out,
    output reg                   port_c_bit5_oe_n,
    input  wire                  port_c_bit4_in,
    output reg                   port_c_bit4_out,
    output reg                   port_c_bit4_oe_n,
    input  wire                  port_c_bit6_in,
    output reg                   port_c_bit6_out,
    output reg                   port_c_bit6_oe_n,
    input  wire                  port_c_bit0_in,
    output reg                   port_c_bit0_out,
    output reg                   port_c_bit0_oe_n,
    input  wire                  port_c_bit1_in,
    output reg                   port_c_bit1_out,
    output reg                   port_c_bit1_oe_n,
    input  wire                  port_c_bit3_in,
    output reg                   port_c_bit3_out,
    output reg                   port_c_bit3_oe_n
);
    localparam S_IDLE = 2'h0;
    localparam S_MRUN = 2'h1;
    localparam S_SRUN = 2'h2;

    // pin slots shared by function select, gpio side and synchroniser
    localparam P_MISO = `SPMS_PIN_MISO;
    localparam P_MOSI = `SPMS_PIN_MOSI;
    localparam P_SCK  = `SPMS_PIN_SCK;
    localparam P_SEL0 = `SPMS_PIN_SEL0;
    localparam P_SEL1 = `SPMS_PIN_SEL1;
    localparam P_SEL3 = `SPMS_PIN_SEL3;

    // pins in order miso, mosi, sck, sel0, sel1, sel3
    wire [5:0] raw_in;
    wire [5:0] pin_s;
    assign raw_in = {port_c_bit3_in, port_c_bit1_in, port_c_bit0_in,
                     port_c_bit6_in, port_c_bit4_in, port_c_bit5_in};

    spms_sync #(.W(6)) u_sync (
        .clock (clock),
        .reset (reset),
        .din   (raw_in),
        .dout  (pin_s)
    );

    // transfer engine state
    reg [1:0] state;
    reg [DW-1:0] shreg;
    reg [`SPMS_LEN_W:0] edges;
    reg [`SPMS_LEN_W:0] target;
    reg sck_q;
    reg mosi_q;
    reg miso_q;
    reg [1:0] sel_q;
    reg sck_prev;
    reg en_prev;

    // divider tick and synchronised pin views
    wire tick;
    wire mrun;
    wire s_sck;
    wire s_en_n;
    wire s_lead;
    wire s_trail;
    wire [DW-1:0] shifted;

    assign mrun = (state == S_MRUN);
    // slave side sees only the synchronised pins
    assign s_sck = pin_s[P_SCK];
    // enable pin in gpio use must never open a slave word
    assign s_en_n = pin_s[P_SEL0] | ~pin_serial_sel[P_SEL0];
    // leading edge samples, trailing edge shifts (mode 0 / mode 2 by cpol)
    assign s_lead = (s_sck != sck_prev) && (s_sck != cpol);
    assign s_trail = (s_sck != sck_prev) && (s_sck == cpol);
    assign shifted = {shreg[DW-2:0], 1'b0};

    spms_clkdiv u_div (
        .clock    (clock),
        .reset    (reset),
        .run      (mrun),
        .half_div (half_div),
        .tick     (tick)
    );

    // msb-aligned transmit word for the selected length
    function [DW-1:0] align;
        input [DW-1:0] d;
        input [`SPMS_LEN_W-1:0] len;
        begin
            align = d << (DW - 1 - len);
        end
    endfunction

    // keeps the received bits only; upper bits still hold transmit residue
    function [DW-1:0] low_mask;
        input [`SPMS_LEN_W:0] nbits;
        begin
            low_mask = ~({DW{1'b1}} << nbits);
        end
    endfunction

    // active-low level of one master select pin; high unless it is chosen while running
    function sel_level;
        input       running;
        input [1:0] chosen;
        input [1:0] which;
        begin
            sel_level = ~(running && (chosen == which));
        end
    endfunction

    // transfer engine; xfer_len holds bits minus one
    // slave timing trails the pins by the two synchroniser stages
    always @(posedge clock) begin
        if (reset) begin
            state    <= S_IDLE;
            shreg    <= {DW{1'b0}};
            edges    <= {(`SPMS_LEN_W+1){1'b0}};
            target   <= {(`SPMS_LEN_W+1){1'b0}};
            sck_q    <= 1'b0;
            mosi_q   <= 1'b0;
            miso_q   <= 1'b0;
            sel_q    <= 2'h0;
            rx_data  <= {DW{1'b0}};
            done     <= 1'b0;
            busy     <= 1'b0;
            sck_prev <= 1'b0;
            en_prev  <= 1'b1;
        end else begin
            done     <= 1'b0;
            sck_prev <= s_sck;
            en_prev  <= s_en_n;
            case (state)
            S_IDLE: begin
                // park the clock at its idle level
                sck_q <= cpol;
                // start is only taken here, so a start while busy is dropped
                if (master_mode && start) begin
                    shreg  <= align(tx_data, xfer_len);
                    mosi_q <= tx_data[xfer_len];
                    target <= {1'b0, xfer_len} + 1'b1;
                    edges  <= {(`SPMS_LEN_W+1){1'b0}};
                    sel_q  <= sel_choice;
                    busy   <= 1'b1;
                    state  <= S_MRUN;
                end else if (!master_mode && !s_en_n && en_prev) begin
                    // falling enable opens a slave word
                    shreg  <= align(tx_data, xfer_len);
                    miso_q <= tx_data[xfer_len];
                    target <= {1'b0, xfer_len} + 1'b1;
                    edges  <= {(`SPMS_LEN_W+1){1'b0}};
                    sck_prev <= cpol;
                    busy   <= 1'b1;
                    state  <= S_SRUN;
                end
            end
            S_MRUN: begin
                if (tick) begin
                    sck_q <= ~sck_q;
                    if (sck_q == cpol) begin
                        // leading edge: sample slave data
                        shreg[0] <= pin_s[0];
                    end else begin
                        edges <= edges + 1'b1;
                        if (edges + 1'b1 == target) begin
                            rx_data <= shreg & low_mask(target);
                            done    <= 1'b1;
                            busy    <= 1'b0;
                            state   <= S_IDLE;
                        end else begin
                            shreg  <= shifted;
                            // next bit down; the top bit is already on the line
                            mosi_q <= shreg[DW-2];
                        end
                    end
                end
            end
            S_SRUN: begin
                // enable released mid-word: drop the word without done
                if (s_en_n) begin
                    busy  <= 1'b0;
                    state <= S_IDLE;
                end else if (s_lead) begin
                    shreg[0] <= pin_s[1];
                end else if (s_trail) begin
                    edges <= edges + 1'b1;
                    if (edges + 1'b1 == target) begin
                        // word complete; reload so the next word follows at once
                        rx_data <= shreg & low_mask(target);
                        done    <= 1'b1;
                        edges   <= {(`SPMS_LEN_W+1){1'b0}};
                        shreg   <= align(tx_data, xfer_len);
                        miso_q  <= tx_data[xfer_len];
                    end else begin
                        shreg  <= shifted;
                        miso_q <= shreg[DW-2];
                    end
                end
            end
            default: state <= S_IDLE;
            endcase
        end
    end

    // pin muxing; reset leaves everything as port C gpio inputs
    // every pin output is registered, one cycle behind the engine
    always @(posedge clock) begin
        if (reset) begin
            port_c_bit5_out <= 1'b0;
            port_c_bit5_oe_n <= 1'b1;
            port_c_bit4_out <= 1'b0;
            port_c_bit4_oe_n <= 1'b1;
            port_c_bit6_out <= 1'b0;
            port_c_bit6_oe_n <= 1'b1;
            port_c_bit0_out <= 1'b0;
            port_c_bit0_oe_n <= 1'b1;
            port_c_bit1_out <= 1'b0;
            port_c_bit1_oe_n <= 1'b1;
            port_c_bit3_out <= 1'b0;
            port_c_bit3_oe_n <= 1'b1;
            gpio_in <= 6'h00;
        end else begin
            // gpio_in tracks every pin whatever its function
            gpio_in <= pin_s;

            // miso: slave drives only while enabled, else released
            if (pin_serial_sel[P_MISO]) begin
                port_c_bit5_out  <= miso_q;
                port_c_bit5_oe_n <= master_mode | s_en_n;
            end else begin
                port_c_bit5_out  <= gpio_out[P_MISO];
                port_c_bit5_oe_n <= gpio_oe_n[P_MISO];
            end

            // mosi: output as master, input as slave
            if (pin_serial_sel[P_MOSI]) begin
                port_c_bit4_out  <= mosi_q;
                port_c_bit4_oe_n <= ~master_mode;
            end else begin
                port_c_bit4_out  <= gpio_out[P_MOSI];
                port_c_bit4_oe_n <= gpio_oe_n[P_MOSI];
            end

            // sck idles at cpol between words so a slave sees no stray edge
            if (pin_serial_sel[P_SCK]) begin
                port_c_bit6_out  <= mrun ? sck_q : cpol;
                port_c_bit6_oe_n <= ~master_mode;
            end else begin
                port_c_bit6_out  <= gpio_out[P_SCK];
                port_c_bit6_oe_n <= gpio_oe_n[P_SCK];
            end

            // select 0 doubles as the slave enable input outside master mode
            if (pin_serial_sel[P_SEL0]) begin
                port_c_bit0_out  <= sel_level(mrun, sel_q, 2'h0);
                port_c_bit0_oe_n <= ~master_mode;
            end else begin
                port_c_bit0_out  <= gpio_out[P_SEL0];
                port_c_bit0_oe_n <= gpio_oe_n[P_SEL0];
            end

            // selects 1 and 3 float while not in master mode
            if (pin_serial_sel[P_SEL1]) begin
                port_c_bit1_out  <= sel_level(mrun, sel_q, 2'h1);
                port_c_bit1_oe_n <= ~master_mode;
            end else begin
                port_c_bit1_out  <= gpio_out[P_SEL1];
                port_c_bit1_oe_n <= gpio_oe_n[P_SEL1];
            end

            // select 3 mirrors select 1
            if (pin_serial_sel[P_SEL3]) begin
                port_c_bit3_out  <= sel_level(mrun, sel_q, 2'h3);
                port_c_bit3_oe_n <= ~master_mode;
            end else begin
                port_c_bit3_out  <= gpio_out[P_SEL3];
                port_c_bit3_oe_n <= gpio_oe_n[P_SEL3];
            end
        end
    end
endmodule // spms_port

// ### testbench/spms_port_monitor.sv
// pin-level checker for the master/slave serial port
`timescale 1ns/1ps
module spms_monitor (
    input wire       clock,
    input wire       reset,
    input wire [5:0] pin_serial_sel,
    input wire       master_mode,
    input wire [1:0] sel_choice,
    input wire       busy,
    input wire       port_c_bit0_in,
    input wire       port_c_bit0_out,
    input wire       port_c_bit6_out,
    input wire       port_c_bit0_oe_n,
    input wire       port_c_bit1_oe_n,
    input wire       port_c_bit3_oe_n,
    input wire       port_c_bit4_oe_n,
    input wire       port_c_bit5_oe_n,
    input wire       port_c_bit6_oe_n
);
    reg        mq;
    reg  [5:0] sq;
    // settings held two edges, so registered pin enables have caught up
    wire       m2 = master_mode & mq;
    wire       s2 = ~master_mode & ~mq;
    wire [5:0] p2 = pin_serial_sel & sq;
    always @(posedge clock) begin
        mq <= master_mode;
        sq <= pin_serial_sel;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_miso_in; m2 && p2[0] |-> port_c_bit5_oe_n; endproperty
    a_miso_in: assert property (p_miso_in) else $error("miso driven as master");
    property p_mosi_in; s2 && p2[1] |-> port_c_bit4_oe_n; endproperty
    a_mosi_in: assert property (p_mosi_in) else $error("mosi driven as slave");
    property p_sck_in; s2 && p2[2] |-> port_c_bit6_oe_n; endproperty
    a_sck_in: assert property (p_sck_in) else $error("sck driven as slave");
    property p_sel1_off; s2 && p2[4] |-> port_c_bit1_oe_n; endproperty
    a_sel1_off: assert property (p_sel1_off) else $error("select 1 driven as slave");
    property p_sel3_off; s2 && p2[5] |-> port_c_bit3_oe_n; endproperty
    a_sel3_off: assert property (p_sel3_off) else $error("select 3 driven as slave");
    // slow edges only: a half period never shorter than eight core cycles
    property p_sck_rate;
        m2 && p2[2] && $changed(port_c_bit6_out) |=> $stable(port_c_bit6_out)[*7];
    endproperty
    a_sck_rate: assert property (p_sck_rate) else $error("sck half period too short");
    property p_sel0_drive;
        busy && $past(busy) && m2 && p2[3] && sel_choice == 2'h0
            |-> !port_c_bit0_oe_n && !port_c_bit0_out;
    endproperty
    a_sel0_drive: assert property (p_sel0_drive) else $error("select 0 not low");
    property p_idle_slave;
        (s2 && p2[0] && port_c_bit0_in)[*6] |-> port_c_bit5_oe_n && !busy;
    endproperty
    a_idle_slave: assert property (p_idle_slave) else $error("slave active unselected");
    property p_reset_gpio;
        $fell(reset) |-> &{port_c_bit0_oe_n, port_c_bit1_oe_n, port_c_bit3_oe_n,
                           port_c_bit4_oe_n, port_c_bit5_oe_n, port_c_bit6_oe_n};
    endproperty
    a_reset_gpio: assert property (p_reset_gpio) else $error("pin driven after reset");
endmodule // spms_monitor
bind spms_port spms_monitor u_mon (.*);

// ### testbench/spms_slave_model.sv
// behavioural serial slave facing the port in master mode
`timescale 1ns/1ps
module spms_slave_model (
    input  wire        sel_n,
    input  wire        sck,
    input  wire        mosi,
    input  wire        cpol,
    input  wire [31:0] tx_word,
    output reg         miso,
    output reg  [31:0] rx_word
);
    reg [31:0] sh;
    initial begin
        miso = 1'b1;
        rx_word = 32'h00000000;
    end
    // select low loads the word; release shows the inverse, never a held bit
    always @(negedge sel_n) begin
        sh = tx_word;
        miso = tx_word[31];
    end
    always @(posedge sel_n) miso = ~miso;
    // clock only received: leading edge samples, trailing edge shifts
    always @(sck) begin
        if (!sel_n && sck !== cpol) rx_word = {rx_word[30:0], mosi};
        else if (!sel_n) begin
            sh = {sh[30:0], 1'b0};
            miso = sh[31];
        end
    end
endmodule // spms_slave_model

// ### testbench/test_spms_port.sv
// self-checking bench for the master/slave serial port
`timescale 1ns/1ps
module test_spms_port;
    reg         clock, reset, master_mode, cpol, start, m_sck, m_mosi, m_sel;
    reg  [5:0]  pin_serial_sel, gpio_out, gpio_oe_n;
    reg  [7:0]  half_div, got;
    reg  [4:0]  xfer_len;
    reg  [1:0]  sel_choice;
    reg  [31:0] tx_data, s_tx, mask;
    wire [31:0] rx_data, s_rx;
    wire [5:0]  gpio_in;
    wire        done, busy, s_miso, o5, e5, o4, e4, o6, e6, o0, e0, o1, e1, o3, e3;
    integer     mismatches, cmp_count, c, mn;
    // released selects 1 and 3 pulled up; released miso driven by the slave model in master mode, else pulled up; other released pins driven here
    wire        l4 = e4 ? m_mosi : o4;
    wire        l6 = e6 ? m_sck : o6;
    wire        l0 = e0 ? m_sel : o0;
    wire        l1 = e1 | o1;
    wire        l3 = e3 | o3;
    wire        l5 = !e5 ? o5 : (master_mode ? s_miso : 1'b1);
    spms_port u_dut (
        .clock(clock), .reset(reset), .pin_serial_sel(pin_serial_sel), .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n), .gpio_in(gpio_in), .master_mode(master_mode),
        .half_div(half_div), .xfer_len(xfer_len), .cpol(cpol), .sel_choice(sel_choice),
        .start(start), .tx_data(tx_data), .rx_data(rx_data), .done(done), .busy(busy),
        .port_c_bit5_in(l5), .port_c_bit5_out(o5), .port_c_bit5_oe_n(e5),
        .port_c_bit4_in(l4), .port_c_bit4_out(o4), .port_c_bit4_oe_n(e4),
        .port_c_bit6_in(l6), .port_c_bit6_out(o6), .port_c_bit6_oe_n(e6),
        .port_c_bit0_in(l0), .port_c_bit0_out(o0), .port_c_bit0_oe_n(e0),
        .port_c_bit1_in(l1), .port_c_bit1_out(o1), .port_c_bit1_oe_n(e1),
        .port_c_bit3_in(l3), .port_c_bit3_out(o3), .port_c_bit3_oe_n(e3));
    spms_slave_model u_slave (.sel_n(l0 & l1 & l3), .sck(l6), .mosi(l4), .cpol(cpol),
        .tx_word(s_tx), .miso(s_miso), .rx_word(s_rx));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task chk(input [31:0] g, input [31:0] e);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task results;
        begin
            $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
            if (mismatches == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // pins start as inputs, then follow the general-purpose settings
    task t_gpio;
        begin
            chk({e3, e1, e0, e6, e4, e5}, 6'h3F);
            gpio_oe_n = 6'h00;
            for (c = 0; c < 2; c = c + 1) begin
                gpio_out = c ? 6'h15 : 6'h2A;
                repeat (4) @(negedge clock);
                chk({o3, o1, o0, o6, o4, o5, e3, e1, e0, e6, e4, e5}, {gpio_out, 6'h00});
                chk(gpio_in, gpio_out);
            end
            gpio_oe_n = 6'h3F;
            pin_serial_sel = 6'h3F;
            master_mode = 1'b1;
        end
    endtask
    // one master word: select, bit count, clock rate and both data lines
    task t_master(input [4:0] len, input [1:0] sc, input [2:0] sx, input pol,
                  input [7:0] hd, input [31:0] d, input [31:0] sd);
        begin
            xfer_len = len;
            sel_choice = sc;
            cpol = pol;
            half_div = hd;
            tx_data = d;
            s_tx = sd;
            repeat (10) @(negedge clock);
            start = 1'b1;
            @(negedge clock);
            start = 1'b0;
            repeat (4) @(negedge clock);
            chk({l3, l1, l0}, sx);
            c = 5;
            while (done !== 1'b1 && c < 3000) begin
                @(negedge clock);
                c = c + 1;
            end
            mn = 2 * (len + 1) * (hd < 8 ? 8 : hd) - 2;
            mask = 32'hFFFFFFFF >> (31 - len);
            chk(c >= mn && c < mn + 40, 1);
            chk(rx_data, sd >> (31 - len));
            chk(s_rx & mask, d & mask);
            chk({e6, e4, e5}, 3'h1);
        end
    endtask
    // one serial bit from the bench acting as master, sampled on the rise
    task sbit(input b);
        begin
            m_mosi = b;
            #80 m_sck = 1'b1;
            got = {got[6:0], l5};
            #80 m_sck = 1'b0;
        end
    endtask
    // slave: ignored while unselected, full byte exchange once selected
    task t_slave(input [7:0] d, input [7:0] sd);
        begin
            master_mode = 1'b0;
            xfer_len = 5'h07;
            cpol = 1'b0;
            tx_data = {24'h000000, d};
            repeat (10) @(negedge clock);
            for (c = 7; c >= 0; c = c - 1) sbit(sd[c]);
            repeat (10) @(negedge clock);
            chk({busy, e5, e6, e1, e3}, 5'h0F);
            m_sel = 1'b0;
            repeat (10) @(negedge clock);
            for (c = 7; c >= 0; c = c - 1) sbit(sd[c]);
            repeat (10) @(negedge clock);
            chk(rx_data, {24'h000000, sd});
            chk(got, d);
            chk(e5, 1'b0);
            m_sel = 1'b1;
        end
    endtask
    initial begin
        #400000;
        mismatches = mismatches + 1;
        results;
    end
    initial begin
        mismatches = 0;
        cmp_count = 0;
        reset = 1'b1;
        {master_mode, cpol, start, m_sck, m_mosi, m_sel} = 6'h01;
        {pin_serial_sel, gpio_out, gpio_oe_n} = {6'h00, 6'h00, 6'h3F};
        {half_div, xfer_len, sel_choice, tx_data, s_tx} = 0;
        repeat (16) @(negedge clock);
        reset = 1'b0;
        @(negedge clock);
        t_gpio;
        t_master(5'h07, 2'h0, 3'h6, 1'b0, 8'h02, 32'h000000A5, 32'h3C000000);
        t_master(5'h00, 2'h1, 3'h5, 1'b1, 8'h09, 32'h00000001, 32'h80000000);
        t_master(5'h1F, 2'h3, 3'h3, 1'b0, 8'h08, 32'hC3A50F96, 32'h5A0FC369);
        t_slave(8'h96, 8'h5C);
        results;
    end
endmodule // test_spms_port
